// File: rtl/tws_control.sv
// Purpose: Three-wire start/stop/direction logic for a motor drive
// Assumes: Terminal inputs are asynchronous and active high
// Notes: Profiles are generated elsewhere; this block gives run and direction
`timescale 1ns/1ps
`default_nettype none
module tws_control
    import tws_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_TERM-1:0] term_in,
    input wire logic [7:0] term_func_0,
    input wire logic [7:0] term_func_1,
    input wire logic [7:0] term_func_2,
    input wire logic factory_load,
    input wire logic [1:0] run_source,
    input wire logic keypad_run,
    input wire logic keypad_stop,
    input wire tws_net_s net_cmd,
    input wire logic net_select,
    output tws_drive_s drive_out,
    output logic [7:0] func_0_active,
    output logic [7:0] func_1_active,
    output logic [7:0] func_2_active
);

    // ****************************************
    // Terminal function assignment
    // ****************************************
    logic [7:0] func_ff [NUM_TERM];
    logic [7:0] nxt_func [NUM_TERM];

    always_comb begin
        nxt_func[0] = term_func_0;
        nxt_func[1] = term_func_1;
        nxt_func[2] = term_func_2;
        if (factory_load) begin
            nxt_func[0] = FUNC_NONE;
            nxt_func[1] = FUNC_NONE;
            nxt_func[2] = FUNC_NONE;
            nxt_func[STOP_TERM_DEFAULT] = FUNC_STOP;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_TERM; i++) begin
            if (reset) begin
                func_ff[i] <= (i == STOP_TERM_DEFAULT) ? FUNC_STOP : FUNC_NONE;
            end else begin
                func_ff[i] <= nxt_func[i];
            end
        end
    end

    assign func_0_active = func_ff[0];
    assign func_1_active = func_ff[1];
    assign func_2_active = func_ff[2];

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [NUM_TERM-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
    logic [NUM_TERM-1:0] nxt_clean;

    always_comb begin
        for (int i = 0; i < NUM_TERM; i++) begin
            nxt_clean[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : clean_ff[i];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
        end else begin
            s1_ff <= term_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            clean_ff <= nxt_clean;
        end
    end

    // ****************************************
    // Function decode helpers
    // ****************************************
    // A level counts only on a terminal that carries the function code
    function automatic logic pick(input logic [7:0] code, input logic [NUM_TERM-1:0] lv,
                                  input logic [7:0] f0, input logic [7:0] f1,
                                  input logic [7:0] f2);
        pick = (f0 == code && lv[0]) || (f1 == code && lv[1]) || (f2 == code && lv[2]);
    endfunction

    function automatic logic has(input logic [7:0] code, input logic [7:0] f0,
                                 input logic [7:0] f1, input logic [7:0] f2);
        has = (f0 == code) || (f1 == code) || (f2 == code);
    endfunction

    // ****************************************
    // Run state
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_LOCK = 2'b10
    } tws_state_e;

    // Idle waits for a start edge, keypad run or net command.
    // Run holds until stop, keypad stop or net command drop.
    // Lock holds a net forward run halted by stop until forward is released,
    // so a held forward level cannot restart the motor on its own.
    tws_state_e state_ff, nxt_state;
    logic start_prev_ff, nxt_start_prev;
    logic stop_prev_ff;
    logic net_fwd_prev_ff, nxt_net_fwd_prev;
    tws_drive_s drive_ff, nxt_drive;
    logic start_lvl, stop_lvl, dir_lvl, start_edge, net_fwd_edge, src_term, stop_any;

    always_comb begin
        start_lvl = pick(FUNC_START, clean_ff, func_ff[0], func_ff[1], func_ff[2]);
        stop_lvl = pick(FUNC_STOP, clean_ff, func_ff[0], func_ff[1], func_ff[2]);
        dir_lvl = pick(FUNC_DIR, clean_ff, func_ff[0], func_ff[1], func_ff[2]);
        src_term = (run_source == SRC_TERMINAL);
        start_edge = src_term && start_lvl && !start_prev_ff;
        net_fwd_edge = net_cmd.fwd && !net_fwd_prev_ff;
        stop_any = stop_lvl || (!net_select && keypad_stop);
        nxt_start_prev = start_lvl;
        nxt_net_fwd_prev = net_cmd.fwd;
        nxt_state = state_ff;
        nxt_drive = drive_ff;
        case (state_ff)
            ST_IDLE: begin
                if (stop_lvl) begin
                    nxt_state = ST_IDLE;
                end else if (start_edge) begin
                    nxt_state = ST_RUN;
                end else if (!net_select && !src_term && keypad_run && !keypad_stop) begin
                    nxt_state = ST_RUN;
                end else if (net_select && (net_fwd_edge || net_cmd.rev)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_any) begin
                    nxt_state = (net_select && net_cmd.fwd) ? ST_LOCK : ST_IDLE;
                end else if (net_select && !net_cmd.fwd && !net_cmd.rev) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_LOCK: begin
                if (!net_select || !net_cmd.fwd) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        // Stop released with start still held resumes the run
        if (state_ff == ST_IDLE && src_term && !stop_lvl && start_lvl &&
            start_prev_ff && stop_prev_ff) begin
            nxt_state = ST_RUN;
        end
        nxt_drive.run = (nxt_state == ST_RUN) && !stop_lvl;
        if (net_select) begin
            nxt_drive.reverse = net_cmd.rev && !net_cmd.fwd;
        end else if (has(FUNC_DIR, func_ff[0], func_ff[1], func_ff[2])) begin
            nxt_drive.reverse = dir_lvl;
        end else begin
            nxt_drive.reverse = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            start_prev_ff <= 1'b0;
            net_fwd_prev_ff <= 1'b0;
            stop_prev_ff <= 1'b0;
            drive_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            start_prev_ff <= nxt_start_prev;
            net_fwd_prev_ff <= nxt_net_fwd_prev;
            stop_prev_ff <= stop_lvl;
            drive_ff <= nxt_drive;
        end
    end

    assign drive_out = drive_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_stop_forces_off: assert property (@(posedge clk) disable iff (reset)
        stop_lvl |=> !drive_out.run) else $error("run while stop active");
    a_stop_halts_net: assert property (@(posedge clk) disable iff (reset)
        (stop_lvl && net_select) |=> !drive_out.run) else $error("net run not halted");
    a_edge_starts: assert property (@(posedge clk) disable iff (reset)
        (start_edge && !stop_lvl && state_ff == ST_IDLE) |=> drive_out.run)
        else $error("start edge ignored");
    a_source_gate: assert property (@(posedge clk) disable iff (reset)
        (!src_term && !net_select && !keypad_run && state_ff == ST_IDLE) |=> !drive_out.run)
        else $error("start taken outside terminal control");
    a_dir_follow: assert property (@(posedge clk) disable iff (reset)
        (!net_select && has(FUNC_DIR, func_ff[0], func_ff[1], func_ff[2]))
        |=> drive_out.reverse == $past(dir_lvl)) else $error("direction not followed");
    a_fwd_only: assert property (@(posedge clk) disable iff (reset)
        (!net_select && !has(FUNC_DIR, func_ff[0], func_ff[1], func_ff[2]))
        |=> !drive_out.reverse) else $error("reverse without direction terminal");
    a_lock_holds: assert property (@(posedge clk) disable iff (reset)
        (state_ff == ST_LOCK && net_select && net_cmd.fwd) |=> !drive_out.run)
        else $error("restart without forward release");
    a_factory_stop: assert property (@(posedge clk) disable iff (reset)
        factory_load |=> func_ff[STOP_TERM_DEFAULT] == FUNC_STOP)
        else $error("stop not on second terminal");
    a_sync_delay: assert property (@(posedge clk) disable iff (reset)
        (s2_ff[0] && s3_ff[0]) |=> clean_ff[0])
        else $error("synchroniser too slow");

    // ****************************************
    // Synchroniser and start history checks
    // ****************************************
    a_sync_agree: assert property (@(posedge clk) disable iff (reset)
        (s2_ff == s3_ff) |=> (clean_ff == $past(s3_ff)))
        else $error("agreed sample not taken");

    a_sync_hold0: assert property (@(posedge clk) disable iff (reset)
        (s2_ff[0] != s3_ff[0]) |=> (clean_ff[0] == $past(clean_ff[0])))
        else $error("terminal 0 glitch passed");

    a_sync_hold1: assert property (@(posedge clk) disable iff (reset)
        (s2_ff[1] != s3_ff[1]) |=> (clean_ff[1] == $past(clean_ff[1])))
        else $error("terminal 1 glitch passed");

    a_sync_hold2: assert property (@(posedge clk) disable iff (reset)
        (s2_ff[2] != s3_ff[2]) |=> (clean_ff[2] == $past(clean_ff[2])))
        else $error("terminal 2 glitch passed");

    a_start_prev: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> (start_prev_ff == $past(start_lvl)))
        else $error("start history lost");

    // ****************************************
    // Function and run state checks
    // ****************************************
    a_func_follow: assert property (@(posedge clk) disable iff (reset)
        !factory_load |=> (func_0_active == $past(term_func_0) &&
        func_1_active == $past(term_func_1) && func_2_active == $past(term_func_2)))
        else $error("terminal function not taken");

    a_factory_none: assert property (@(posedge clk) disable iff (reset)
        factory_load |=> (func_0_active == FUNC_NONE && func_2_active == FUNC_NONE))
        else $error("factory load left a function");

    a_level_idle: assert property (@(posedge clk) disable iff (reset)
        (state_ff == ST_IDLE && !start_lvl && !net_select && !keypad_run) |=> !drive_out.run)
        else $error("run without start");

    a_stop_ends: assert property (@(posedge clk) disable iff (reset)
        (state_ff == ST_RUN && stop_lvl) |=> (state_ff != ST_RUN))
        else $error("stop did not end run");

    a_resume_run: assert property (@(posedge clk) disable iff (reset)
        (state_ff == ST_IDLE && src_term && !stop_lvl && start_lvl && start_prev_ff &&
        stop_prev_ff) |=> drive_out.run)
        else $error("run not resumed after stop release");

    a_lock_free: assert property (@(posedge clk) disable iff (reset)
        (state_ff == ST_LOCK && !net_cmd.fwd) |=> (state_ff == ST_IDLE))
        else $error("lock not left on forward release");
endmodule
`default_nettype wire

// File: rtl/tws_pkg.sv
// Purpose: Constants and types for the three-wire start/stop control block
// Assumes: Terminal function codes are 8-bit values, run source code is 2 bits
// Notes: Shared by the control module and its assertions
package tws_pkg;
    localparam int NUM_TERM = 3;
    localparam logic [7:0] FUNC_START = 8'h14;
    localparam logic [7:0] FUNC_STOP = 8'h15;
    localparam logic [7:0] FUNC_DIR = 8'h16;
    localparam logic [7:0] FUNC_NONE = 8'hff;
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam int STOP_TERM_DEFAULT = 1;

    typedef struct packed {
        logic run;
        logic reverse;
    } tws_drive_s;

    typedef struct packed {
        logic fwd;
        logic rev;
    } tws_net_s;
endpackage

// File: testbench/tb_three_wire_start_stop_control.sv
// Purpose: Self-checking bench for the three-wire start/stop control block
// Assumes: Inputs change at the falling clock edge
// Notes: Every wait on the drive output is bounded
`timescale 1ns/1ps
`default_nettype none
module tb_three_wire_start_stop_control
    import tws_pkg::*;
;
    logic clk = 0;
    logic reset = 1;
    logic start_pulse_in = 0;
    logic stop_hold_in = 0;
    logic dir = 0;
    logic nfwd = 0;
    logic fl = 1;
    logic nsel = 0;
    logic [7:0] f0 = FUNC_NONE;
    logic [7:0] f1 = FUNC_NONE;
    logic [7:0] f2 = FUNC_NONE;
    logic [1:0] src = 2'h0;
    logic [NUM_TERM-1:0] term;
    tws_net_s ncmd;
    tws_drive_s drv;
    logic [7:0] a0, a1, a2;
    int errors = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    tws_far_side u_far (.start_btn(start_pulse_in), .stop_btn(stop_hold_in), .dir_sw(dir),
        .net_fwd(nfwd),
        .term_in(term), .net_cmd(ncmd));
    tws_control u_dut (.clk(clk), .reset(reset), .term_in(term), .term_func_0(f0),
        .term_func_1(f1), .term_func_2(f2), .factory_load(fl), .run_source(src),
        .keypad_run(1'b0), .keypad_stop(1'b0), .net_cmd(ncmd), .net_select(nsel),
        .drive_out(drv), .func_0_active(a0), .func_1_active(a1), .func_2_active(a2));
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Waits for drive output {run, reverse} to reach exp
    task automatic wait_out(input logic [1:0] exp);
        int i;
        for (i = 0; i < 12 && drv !== exp; i++) begin
            @(negedge clk);
        end
        chk({6'h0, drv}, {6'h0, exp});
        if (i == 12) begin
            print_verdict();
        end
    endtask
    task automatic press_start();
        start_pulse_in = 1;
        cyc(6);
        start_pulse_in = 0;
    endtask
    task automatic hit_stop();
        stop_hold_in = 1;
        wait_out(2'b00);
        stop_hold_in = 0;
        cyc(6);
    endtask
    initial begin
        cyc(2);
        reset = 0;
        cyc(1);
        chk(a1, FUNC_STOP);
        chk(a0, FUNC_NONE);
        chk({6'h0, drv}, 8'h00);
        fl = 0;
        f0 = FUNC_START;
        f1 = FUNC_STOP;
        f2 = FUNC_DIR;
        cyc(3);
        chk(a0, FUNC_START);
        chk(a2, FUNC_DIR);
        press_start();
        cyc(10);
        chk({6'h0, drv}, 8'h00);
        src = 2'h1;
        cyc(4);
        press_start();
        wait_out(2'b10);
        cyc(10);
        chk({6'h0, drv}, 8'h02);
        dir = 1;
        wait_out(2'b11);
        dir = 0;
        wait_out(2'b10);
        stop_hold_in = 1;
        wait_out(2'b00);
        start_pulse_in = 1;
        cyc(10);
        chk({6'h0, drv}, 8'h00);
        stop_hold_in = 0;
        wait_out(2'b10);
        start_pulse_in = 0;
        hit_stop();
        f2 = FUNC_NONE;
        dir = 1;
        press_start();
        wait_out(2'b10);
        cyc(6);
        chk({6'h0, drv}, 8'h02);
        hit_stop();
        dir = 0;
        nsel = 1;
        nfwd = 1;
        wait_out(2'b10);
        hit_stop();
        cyc(6);
        chk({6'h0, drv}, 8'h00);
        nfwd = 0;
        cyc(6);
        nfwd = 1;
        wait_out(2'b10);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: testbench/tws_far_side.sv
// Purpose: Far-side model: start and stop pushbuttons, direction selector, network run levels
// Assumes: Terminal 0 wired to start, terminal 1 to stop, terminal 2 to direction
// Notes: Steady run comes from the network levels, or from the control block latching a momentary start button press
`timescale 1ns/1ps
`default_nettype none
module tws_far_side
    import tws_pkg::*;
(
    input wire logic start_btn,
    input wire logic stop_btn,
    input wire logic dir_sw,
    input wire logic net_fwd,
    output logic [NUM_TERM-1:0] term_in,
    output tws_net_s net_cmd
);
    assign term_in = {dir_sw, stop_btn, start_btn};
    assign net_cmd = '{fwd: net_fwd, rev: 1'b0};
endmodule
`default_nettype wire
